// ==== rtl/ser_core.sv ====
// status byte, standard event status and enable masks with service request
`timescale 1ns/1ns

`include "ser_map.svh"

module ser_core
  import ser_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire ser_req_t req_i,
  input wire ser_evt_t event_i,
  input wire logic msg_avail_i,
  input wire logic serial_poll_i,
  output ser_resp_t resp_o,
  output logic [7:0] status_byte_o,
  output logic [7:0] poll_byte_o,
  output logic srq_n_o,
  output logic evq_release_o
);

  // ==========================================================
  // registers and next values
  logic [7:0] std_event_r;
  logic [7:0] std_event_nxt;
  logic [7:0] dev_mask_r;
  logic [7:0] esum_mask_r;
  logic [7:0] srq_mask_r;
  logic pon_pending_r;
  logic rqs_r;
  logic rqs_nxt;
  logic summary_r;
  ser_poll_t poll_state_r;
  ser_poll_t poll_state_nxt;
  ser_resp_t resp_r;
  ser_resp_t resp_nxt;
  logic [7:0] status_byte_r;
  logic [7:0] poll_byte_r;
  logic srq_n_r;
  logic evq_release_r;

  // ==========================================================
  // decoded strobes
  logic set_dev;
  logic set_esum;
  logic set_srq;
  logic qry_events;
  logic poll_end;
  logic [7:0] evt_raw;
  logic [7:0] evt_used;
  logic [7:0] evt_gated;
  logic evt_sum;
  logic msg_flag;
  logic [7:0] stb_plain;
  logic [7:0] stb_enabled;
  logic summary;
  logic summary_rise;

  assign set_dev = req_i.valid && (req_i.cmd == SER_SET_DEV_MASK);
  assign set_esum = req_i.valid && (req_i.cmd == SER_SET_ESUM_MASK);
  assign set_srq = req_i.valid && (req_i.cmd == SER_SET_SRQ_MASK);
  assign qry_events = req_i.valid && (req_i.cmd == SER_QRY_EVENTS);

  // ==========================================================
  // event sources
  assign evt_raw = {event_i.power_on_event || pon_pending_r,
    event_i[6:0]};

  // unused sources are cut off before the mask
  assign evt_used = evt_raw & `SER_EVT_USED_MASK;

  // ==========================================================
  // per-bit event latch
  genvar gi;
  generate
    for (gi = 0; gi < `SER_REG_W; gi = gi + 1)
    begin : g_evt
      // an event passes only when its device enable bit is set
      assign evt_gated[gi] = evt_used[gi] && dev_mask_r[gi];

      // set wins over the clear of the event status query
      assign std_event_nxt[gi] = evt_gated[gi] ||
        (std_event_r[gi] && !qry_events);
    end
  endgenerate

  // ==========================================================
  // power-on event, one shot after reset release
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pon_pending_r <= 1'b1;
    end
    else
    begin
      pon_pending_r <= 1'b0;
    end
  end

  // ==========================================================
  // standard event status register
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      std_event_r <= `SER_STD_EVENT_RST;
    end
    else
    begin
      std_event_r <= std_event_nxt;
    end
  end

  // ==========================================================
  // enable masks
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dev_mask_r <= `SER_DEV_MASK_RST;
    end
    else if (set_dev)
    begin
      dev_mask_r <= req_i.data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      esum_mask_r <= `SER_ESUM_MASK_RST;
    end
    else if (set_esum)
    begin
      esum_mask_r <= req_i.data;
    end
  end

  // stored as written; bit 6 is left out of the summary below
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      srq_mask_r <= `SER_SRQ_MASK_RST;
    end
    else if (set_srq)
    begin
      srq_mask_r <= req_i.data;
    end
  end

  // ==========================================================
  // status byte and summaries
  assign evt_sum = |(std_event_r & esum_mask_r);
  assign msg_flag = msg_avail_i;

  always_comb
  begin
    stb_plain = `SER_BYTE_ZERO;
    stb_plain[`SER_STB_SUM_BIT] = evt_sum;
    stb_plain[`SER_STB_MSG_BIT] = msg_flag;
  end

  // request bit never feeds its own summary
  assign stb_enabled = stb_plain & srq_mask_r & `SER_SRQ_SUM_MASK;

  assign summary = |stb_enabled;
  assign summary_rise = summary && !summary_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      summary_r <= 1'b0;
    end
    else
    begin
      summary_r <= summary;
    end
  end

  // ==========================================================
  // serial poll tracking
  always_comb
  begin
    poll_state_nxt = poll_state_r;
    case (poll_state_r)
      SER_POLL_IDLE:
        if (serial_poll_i)
          poll_state_nxt = SER_POLL_BUSY;
      SER_POLL_BUSY:
        if (!serial_poll_i)
          poll_state_nxt = SER_POLL_IDLE;
      default:
        poll_state_nxt = SER_POLL_IDLE;
    endcase
  end

  assign poll_end = (poll_state_r == SER_POLL_BUSY) && !serial_poll_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      poll_state_r <= SER_POLL_IDLE;
    end
    else
    begin
      poll_state_r <= poll_state_nxt;
    end
  end

  // ==========================================================
  // request service flag
  // a new rise wins over the poll-end clear
  assign rqs_nxt = summary_rise || (rqs_r && !poll_end);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rqs_r <= 1'b0;
    end
    else
    begin
      rqs_r <= rqs_nxt;
    end
  end

  // ==========================================================
  // query answers
  always_comb
  begin
    resp_nxt.valid = 1'b0;
    resp_nxt.data = `SER_BYTE_ZERO;
    if (req_i.valid)
    begin
      case (req_i.cmd)
        SER_QRY_DEV_MASK:
        begin
          resp_nxt.valid = 1'b1;
          resp_nxt.data = dev_mask_r;
        end
        SER_QRY_ESUM_MASK:
        begin
          resp_nxt.valid = 1'b1;
          resp_nxt.data = esum_mask_r;
        end
        SER_QRY_SRQ_MASK:
        begin
          resp_nxt.valid = 1'b1;
          resp_nxt.data = srq_mask_r;
        end
        SER_QRY_STATUS:
        begin
          resp_nxt.valid = 1'b1;
          resp_nxt.data = stb_plain;
          resp_nxt.data[`SER_STB_REQ_BIT] = summary;
        end
        SER_QRY_EVENTS:
        begin
          resp_nxt.valid = 1'b1;
          resp_nxt.data = std_event_r;
        end
        default:
          resp_nxt.valid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      resp_r <= '0;
    end
    else
    begin
      resp_r <= resp_nxt;
    end
  end

  // ==========================================================
  // event queue release
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      evq_release_r <= 1'b0;
    end
    else
    begin
      evq_release_r <= qry_events;
    end
  end

  // ==========================================================
  // pin-side outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      srq_n_r <= 1'b1;
    end
    else
    begin
      srq_n_r <= !rqs_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      poll_byte_r <= `SER_BYTE_ZERO;
    end
    else
    begin
      poll_byte_r <= stb_plain;
      poll_byte_r[`SER_STB_REQ_BIT] <= rqs_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_byte_r <= `SER_BYTE_ZERO;
    end
    else
    begin
      status_byte_r <= stb_plain;
      status_byte_r[`SER_STB_REQ_BIT] <= summary;
    end
  end

  assign resp_o = resp_r;
  assign status_byte_o = status_byte_r;
  assign poll_byte_o = poll_byte_r;
  assign srq_n_o = srq_n_r;
  assign evq_release_o = evq_release_r;

endmodule : ser_core

// ==== pkg/ser_map.svh ====
// bit positions, widths and reset values of the status and event registers
`ifndef SER_MAP_SVH
`define SER_MAP_SVH

// ==========================================================
// register widths
`define SER_REG_W 8
`define SER_CMD_W 4

// ==========================================================
// status byte fields
`define SER_STB_REQ_BIT 6
`define SER_STB_SUM_BIT 5
`define SER_STB_MSG_BIT 4
`define SER_STB_USED_MASK 8'h70
`define SER_SRQ_SUM_MASK 8'hBF

// ==========================================================
// standard event status fields
`define SER_EVT_POWER_BIT 7
`define SER_EVT_USER_BIT 6
`define SER_EVT_CMD_BIT 5
`define SER_EVT_EXEC_BIT 4
`define SER_EVT_DEV_BIT 3
`define SER_EVT_QUERY_BIT 2
`define SER_EVT_CTRL_BIT 1
`define SER_EVT_DONE_BIT 0
`define SER_EVT_USED_MASK 8'hBD

// ==========================================================
// reset values
`define SER_STD_EVENT_RST 8'h00
`define SER_DEV_MASK_RST 8'h00
`define SER_ESUM_MASK_RST 8'h00
`define SER_SRQ_MASK_RST 8'h00
`define SER_BYTE_ZERO 8'h00

`endif

// ==== pkg/ser_pkg.sv ====
// types shared by the status and event reporting block
package ser_pkg;

  // ==========================================================
  // commands and queries from the message parser
  typedef enum logic [3:0] {
    SER_NOP,
    SER_SET_DEV_MASK,
    SER_QRY_DEV_MASK,
    SER_SET_ESUM_MASK,
    SER_QRY_ESUM_MASK,
    SER_SET_SRQ_MASK,
    SER_QRY_SRQ_MASK,
    SER_QRY_STATUS,
    SER_QRY_EVENTS
  } ser_cmd_t;

  // ==========================================================
  // serial poll tracking
  typedef enum logic [0:0] {
    SER_POLL_IDLE,
    SER_POLL_BUSY
  } ser_poll_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    ser_cmd_t cmd;
    logic [7:0] data;
  } ser_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ser_resp_t;

  typedef struct packed {
    logic power_on_event;
    logic user_request_event;
    logic command_error_event;
    logic execution_error_event;
    logic device_error_event;
    logic query_error_event;
    logic request_control_event;
    logic operation_complete_event;
  } ser_evt_t;

endpackage : ser_pkg

// ==== dv/ser_core_properties.sv ====
// assertions on the status and event reporting core ports
`timescale 1ns/1ns
module ser_core_properties
  import ser_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire ser_req_t req_i,
  input wire logic msg_avail_i,
  input wire logic serial_poll_i,
  input wire ser_resp_t resp_o,
  input wire logic [7:0] status_byte_o,
  input wire logic [7:0] poll_byte_o,
  input wire logic srq_n_o,
  input wire logic evq_release_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ====
  // query requests
  sequence s_qry_stb;
    req_i.valid && req_i.cmd == SER_QRY_STATUS;
  endsequence
  sequence s_qry_evt;
    req_i.valid && req_i.cmd == SER_QRY_EVENTS;
  endsequence
  // ====
  // properties
  property p_unused;
    ((status_byte_o | poll_byte_o) & 8'h8F) == 8'h00;
  endproperty
  property p_stb_resp;
    s_qry_stb |=> resp_o.valid && resp_o.data == status_byte_o;
  endproperty
  property p_evt_resp;
    s_qry_evt |=> resp_o.valid && evq_release_o && !resp_o.data[6]
      && !resp_o.data[1];
  endproperty
  property p_mav;
    1'b1 |-> status_byte_o[4] == $past(msg_avail_i);
  endproperty
  property p_srq_poll;
    srq_n_o == !poll_byte_o[6];
  endproperty
  property p_rqs_rise;
    $rose(status_byte_o[6]) |-> !srq_n_o;
  endproperty
  property p_poll_end;
    $fell(serial_poll_i) |-> ##[0:2] (srq_n_o || $rose(status_byte_o[6]));
  endproperty
  property p_srq_hold;
    $rose(srq_n_o) |-> $past(serial_poll_i) || $past(serial_poll_i, 2)
      || $past(serial_poll_i, 3);
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused status bit set");
  a_stb_resp: assert property (p_stb_resp)
    else $error("status answer wrong");
  a_evt_resp: assert property (p_evt_resp)
    else $error("event answer wrong");
  a_mav: assert property (p_mav)
    else $error("message bit wrong");
  a_srq_poll: assert property (p_srq_poll)
    else $error("request line and poll bit differ");
  a_rqs_rise: assert property (p_rqs_rise)
    else $error("summary rise without request");
  a_poll_end: assert property (p_poll_end)
    else $error("request not cleared at poll end");
  a_srq_hold: assert property (p_srq_hold)
    else $error("request dropped without poll");
endmodule : ser_core_properties

bind ser_core ser_core_properties u_chk (.sys_clk_i, .rst_n_i, .req_i,
  .msg_avail_i, .serial_poll_i, .resp_o, .status_byte_o, .poll_byte_o,
  .srq_n_o, .evq_release_o);

// ==== dv/ser_ctrl_model.sv ====
// bus controller model that serial polls on a service request
`timescale 1ns/1ns
module ser_ctrl_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic srq_n_i,
  input wire logic slow_i,
  output logic poll_o
);
  logic [3:0] cnt_r;
  // ====
  // poll after a short or long delay, four cycles long
  always_ff @(negedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 4'h0;
      poll_o <= 1'b0;
    end
    else if (cnt_r != 4'h0)
    begin
      cnt_r <= cnt_r - 4'h1;
      poll_o <= cnt_r >= 4'h4 && cnt_r <= 4'h7;
    end
    else if (!srq_n_i)
      cnt_r <= slow_i ? 4'hF : 4'h8;
  end
endmodule : ser_ctrl_model

// ==== dv/ser_core_tb_top.sv ====
// self-checking bench for the status and event reporting core
`timescale 1ns/1ns
module ser_core_tb_top
  import ser_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  ser_req_t req_i = '0;
  ser_evt_t event_i = '0;
  logic msg_avail_i = 1'b0;
  logic serial_poll_i;
  logic slow = 1'b0;
  ser_resp_t resp_o;
  logic [7:0] status_byte_o;
  logic [7:0] poll_byte_o;
  logic srq_n_o;
  logic evq_release_o;
  logic [7:0] dev_m, esum_m, srq_m, evt_m, v;
  int bad_count = 0;
  int cmp_count = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  ser_core DUT (.sys_clk_i, .rst_n_i, .req_i, .event_i, .msg_avail_i,
    .serial_poll_i, .resp_o, .status_byte_o, .poll_byte_o, .srq_n_o,
    .evq_release_o);
  ser_ctrl_model u_ctrl (.sys_clk_i, .rst_n_i, .srq_n_i(srq_n_o),
    .slow_i(slow), .poll_o(serial_poll_i));

  // ====
  // helpers
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] exp_stb();
    logic [7:0] b;
    b = {2'b00, |(evt_m & esum_m), msg_avail_i, 4'h0};
    return b | {1'b0, |(b & srq_m), 6'h00};
  endfunction : exp_stb

  function automatic logic is_qry(ser_cmd_t c);
    return c inside {SER_QRY_DEV_MASK, SER_QRY_ESUM_MASK, SER_QRY_SRQ_MASK,
      SER_QRY_STATUS, SER_QRY_EVENTS};
  endfunction : is_qry

  task automatic req(ser_cmd_t c, logic [7:0] d, logic [7:0] exp);
    @(negedge sys_clk_i);
    req_i = '{1'b1, c, d};
    @(negedge sys_clk_i);
    req_i = '0;
    check(c.name(), resp_o.data, exp);
    check("valid", {7'h0, resp_o.valid}, {7'h0, is_qry(c)});
    check("rel", {7'h0, evq_release_o}, {7'h0, c == SER_QRY_EVENTS});
    case (c)
      SER_SET_DEV_MASK: dev_m = d;
      SER_SET_ESUM_MASK: esum_m = d;
      SER_SET_SRQ_MASK: srq_m = d;
      SER_QRY_EVENTS: evt_m = 8'h00;
      default: ;
    endcase
  endtask : req

  task automatic pulse(logic [7:0] e);
    @(negedge sys_clk_i);
    event_i = e;
    evt_m |= e & dev_m & 8'hBD;
    @(negedge sys_clk_i);
    event_i = '0;
  endtask : pulse

  task automatic wait_poll(logic lvl);
    int n;
    n = 0;
    while (serial_poll_i !== lvl && n < 40)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (serial_poll_i !== lvl)
    begin
      bad_count++;
      stop_test();
    end
  endtask : wait_poll

  task automatic srq_run();
    wait_poll(1'b1);
    check("srq_n", {7'h0, srq_n_o}, 8'h00);
    check("poll", poll_byte_o, exp_stb());
    wait_poll(1'b0);
    repeat (3) @(negedge sys_clk_i);
    check("srq_n", {7'h0, srq_n_o}, 8'h01);
    check("poll", poll_byte_o, exp_stb() & 8'hBF);
    check("status", status_byte_o, exp_stb());
  endtask : srq_run

  // ====
  // main sequence
  initial
  begin
    {dev_m, esum_m, srq_m, evt_m} = '0;
    v = 8'($urandom(32'h4f38_5f78));
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    req(SER_QRY_DEV_MASK, 8'h00, 8'h00);
    req(SER_QRY_ESUM_MASK, 8'h00, 8'h00);
    req(SER_QRY_SRQ_MASK, 8'h00, 8'h00);
    req(SER_QRY_EVENTS, 8'h00, 8'h00);
    req(SER_SET_DEV_MASK, 8'hFF, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i);
      req(SER_QRY_EVENTS, 8'h00, evt_m);
    end
    repeat (40)
    begin
      v = 8'($urandom);
      req(SER_SET_DEV_MASK, v, 8'h00);
      req(SER_QRY_DEV_MASK, 8'h00, v);
      v = 8'($urandom);
      req(SER_SET_ESUM_MASK, v, 8'h00);
      req(SER_QRY_ESUM_MASK, 8'h00, v);
      v = 8'($urandom) & 8'hBF;
      req(SER_SET_SRQ_MASK, v, 8'h00);
      req(SER_QRY_SRQ_MASK, 8'h00, v);
      v = 8'($urandom);
      pulse(v);
      req(SER_QRY_STATUS, 8'h00, exp_stb());
      if (v[0])
        req(SER_QRY_EVENTS, 8'h00, evt_m);
    end
    req(SER_SET_SRQ_MASK, 8'h00, 8'h00);
    req(SER_QRY_EVENTS, 8'h00, evt_m);
    req(SER_NOP, 8'hFF, 8'h00);
    repeat (20) @(negedge sys_clk_i);
    req(SER_SET_SRQ_MASK, 8'h10, 8'h00);
    msg_avail_i = 1'b1;
    srq_run();
    msg_avail_i = 1'b0;
    req(SER_SET_ESUM_MASK, 8'hFF, 8'h00);
    req(SER_SET_DEV_MASK, 8'hFF, 8'h00);
    req(SER_SET_SRQ_MASK, 8'h20, 8'h00);
    slow = 1'b1;
    pulse(8'h08);
    srq_run();
    stop_test();
  end
endmodule : ser_core_tb_top
